// ===== elg_pkg.sv
/*
 * Package for the edge event logger: register offsets, field positions,
 * reset values, counts and the carrier types shared by the logger.
 * Assumes one logger clock domain and a plain address/strobe register port.
 */
package elg_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int ADDR_W = 20;   // Register port address width
	localparam int NCH    = 16;   // Input channels and buffer entries
	localparam int NSRC   = 1024; // Selectable sources (10-bit select)

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [19:0] OFS_CTRL    = 20'h48000; // Enable, soft reset
	localparam logic [19:0] OFS_TSEL    = 20'h48004; // Time-stamp timer select
	localparam logic [19:0] OFS_WMARK   = 20'h4800c; // Watermark level
	localparam logic [19:0] OFS_PTR     = 20'h4800e; // Flags and indexes
	localparam logic [19:0] OFS_CHEN    = 20'h48020; // Channel enables
	localparam logic [19:0] OFS_CHSTS   = 20'h48024; // Channel source levels
	localparam logic [19:0] OFS_CHDEF   = 20'h48040; // First channel define
	localparam logic [19:0] OFS_CHDEF_E = 20'h4805e; // Last channel define
	localparam logic [19:0] OFS_FIFO    = 20'h48080; // First entry word
	localparam logic [19:0] OFS_FIFO_E  = 20'h480be; // Last entry word

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_ENA_BIT = 0;  // Logger enable
	localparam int CTRL_RST_BIT = 1;  // Soft reset, write 1
	localparam int PTR_NE_BIT   = 16; // Not-empty flag
	localparam int PTR_WM_BIT   = 17; // Watermark flag
	localparam int PTR_FULL_BIT = 18; // Full flag
	localparam int PTR_W_LSB    = 8;  // Write index position
	localparam int DEF_FILT_BIT = 13; // Repeat filter
	localparam int DEF_POL_BIT  = 14; // Edge polarity
	localparam int DEF_DB_BIT   = 15; // Debounce enable
	localparam int ENT_POL_BIT  = 12; // Entry polarity
	localparam logic [3:0] WMARK_RST = 4'h1;  // Watermark after reset
	localparam logic [4:0] DEPTH     = 5'h10; // Entries in the buffer
	localparam logic [1:0] DB_LAST   = 2'h3;  // Debounce: 4 stable cycles

	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;  // Register offset
		logic [31:0]       wdata; // Write data
		logic              wr;    // Write strobe
		logic              rd;    // Read strobe
	} elg_bus_req_t;

	typedef struct packed {
		logic full;      // Sixteen unread entries
		logic watermark; // Free entries at or below watermark
		logic has_data;  // At least one unread entry
	} elg_flags_t;

	typedef struct packed {
		logic       db;   // Debounce enable
		logic       pol;  // 0 rising, 1 falling
		logic       filt; // Repeat filter
		logic [9:0] sel;  // Source select
	} elg_chdef_t;

	typedef struct packed {
		logic        pol;   // Edge polarity
		logic [9:0]  id;    // Source identifier
		logic [31:0] stamp; // Time stamp
	} elg_entry_t;

	typedef struct packed {
		logic                 en;    // Logger enable
		logic [1:0]           tsel;  // Timer select
		logic [3:0]           wmark; // Watermark level
		logic [3:0]           wptr;  // Write index
		logic [3:0]           rptr;  // Read index
		logic                 full;  // Full state
		logic [15:0]          chen;  // Channel enables
		elg_chdef_t [15:0]    chdef; // Channel setup
		elg_entry_t [15:0]    fifo;  // Buffer entries
		logic [15:0]          qual;  // Qualified levels
		logic [15:0]          prev;  // Last seen qualified levels
		logic [15:0]          pend;  // Events waiting to be logged
		logic [15:0]          chsts; // Source levels for software
		logic [15:0][1:0]     dbc;   // Debounce counters
		logic [31:0]          rdata; // Read data
		elg_flags_t           flags; // Registered flags
	} elg_state_t;

endpackage

// ===== elg_logger.sv
/*
 * Edge event logger: sixteen edge-watching channels, priority queueing,
 * a sixteen-entry circular buffer with time stamps, and its registers.
 * Assumes sys_clk runs on while the processor clock is off; then the
 * timer supplies a one-cycle tick that paces the logger instead.
 */
// Operation
// - Log only selected edges on enabled channels
// - Each entry stores 32-bit timer stamp
// - Pace by processor clock, else timer tick
// - One log per step, lowest channel first
// - Logger enable gates all capture
// - Soft reset clears flags, buffer, indexes
// - Sixteen channels with source, polarity, debounce
// - Filter drops duplicates of unread entries
// - Channel enables act independently while running
// - Each channel sees one edge direction
// - Enabling logs active initial channel levels
// - Circular buffer never overwrites unread entries
// - All entries readable in any order
// - Write index, read index, modulo count
// - Not-empty flag set on unread entries
// - Watermark flag when free reaches level
// - Full stops logging and indication
// - Only a changed read index or a soft reset releases full
// - Flags offered to interrupts and triggers
// - Watermark is four bits, resets to one
// - Polarity zero rising, one falling
// - Source fields ten bits, reset zero
// - Enable at control bit zero, resets off
module elg_logger
	import elg_pkg::*;
(
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst,
	// Register port
	input  wire elg_bus_req_t    bus_req,
	output logic [31:0]          bus_rdata,
	// Logger pacing
	input  wire logic            processor_clock_enable,
	input  wire logic            timer_tick,
	// Time-stamp timer
	input  wire logic [31:0]     stamp_timer_value,
	output logic [1:0]           stamp_timer_select,
	// Monitored sources
	input  wire logic [NSRC-1:0] source_levels,
	// Flags to interrupts, sequencer, firmware trigger and GPIO
	output elg_flags_t           log_flags
);

	// ---------------------------------------------------------------
	// State and working signals
	// ---------------------------------------------------------------
	elg_state_t  q;         // Registered state
	elg_state_t  n;         // Next state
	logic        step;      // Logger clock step
	logic [15:0] raw;       // Selected source levels
	logic        lvl;       // Qualified level of one channel
	logic        hit;       // Edge seen on one channel
	logic        dup;       // Matching unread entry exists
	logic        found;     // Grant already made
	logic [4:0]  cnt;       // Unread entries
	logic [4:0]  free_n;    // Free entries after update
	logic [3:0]  cidx;      // Channel define index
	logic [3:0]  fidx;      // Entry index
	logic [19:0] dofs;      // Offset into channel defines
	logic [19:0] fofs;      // Offset into entries
	logic        srst;      // Soft reset write
	logic        rptr_wr;   // Read index write
	logic [4:0]  free_q;    // Free entries, registered view

	// Outputs straight from state
	assign bus_rdata          = q.rdata;
	assign stamp_timer_select = q.tsel;
	assign log_flags          = q.flags;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	// Computes edges, grants, buffer updates and register accesses
	always_comb begin
		n       = q;
		n.rdata = 32'h0;
		lvl     = 1'b0;
		hit     = 1'b0;
		dup     = 1'b0;
		found   = 1'b0;
		free_n  = 5'h0;
		dofs    = bus_req.addr - OFS_CHDEF;
		fofs    = bus_req.addr - OFS_FIFO;
		cidx    = dofs[4:1];
		fidx    = fofs[5:2];
		srst    = bus_req.wr && bus_req.addr == OFS_CTRL && bus_req.wdata[CTRL_RST_BIT];
		rptr_wr = bus_req.wr && bus_req.addr == OFS_PTR;
		// Processor clock paces when on, timer tick otherwise
		step    = processor_clock_enable | timer_tick;
		// Unread count, full counts as sixteen
		cnt     = q.full ? DEPTH : {1'b0, q.wptr - q.rptr};
		// Source mux and live status per channel
		for (int i = 0; i < NCH; i++) begin
			raw[i]     = source_levels[q.chdef[i].sel];
			n.chsts[i] = raw[i];
		end

		// Grant the lowest pending channel, one per step
		if (step && q.en && !q.full) begin
			for (int i = 0; i < NCH; i++) begin
				if (q.pend[i] && !found) begin
					found                 = 1'b1;
					n.pend[i]             = 1'b0;
					n.fifo[q.wptr].pol    = q.chdef[i].pol;
					n.fifo[q.wptr].id     = q.chdef[i].sel;
					n.fifo[q.wptr].stamp  = stamp_timer_value;
					n.wptr                = q.wptr + 4'h1;
					// Buffer full when the write index meets the read index
					if (q.wptr + 4'h1 == q.rptr) begin
						n.full = 1'b1;
					end
				end
			end
		end

		// Per-channel qualification and edge detection
		for (int i = 0; i < NCH; i++) begin
			lvl = q.qual[i];
			hit = 1'b0;
			dup = 1'b0;
			if (step) begin
				if (q.chdef[i].db) begin
					// Level must differ for four steps in a row
					if (raw[i] != q.qual[i]) begin
						if (q.dbc[i] == DB_LAST) begin
							lvl       = raw[i];
							n.dbc[i]  = 2'h0;
						end else begin
							n.dbc[i] = q.dbc[i] + 2'h1;
						end
					end else begin
						n.dbc[i] = 2'h0;
					end
				end else begin
					lvl      = raw[i];
					n.dbc[i] = 2'h0;
				end
				n.qual[i] = lvl;
			end
			if (!q.en) begin
				// Arm at the inactive level so an active start logs once
				n.prev[i] = q.chdef[i].pol;
				n.pend[i] = 1'b0;
			end else if (step) begin
				n.prev[i] = lvl;
				// Only the edge toward the polarity's active level counts
				hit = q.chen[i] && lvl != q.prev[i] && lvl == ~q.chdef[i].pol;
			end
			// Look for an unread entry of the same source and polarity
			for (int k = 0; k < NCH; k++) begin
				if ((q.full || {1'b0, 4'(k[3:0] - q.rptr)} < cnt)
						&& q.fifo[k].id == q.chdef[i].sel
						&& q.fifo[k].pol == q.chdef[i].pol) begin
					dup = 1'b1;
				end
			end
			// New event queues; a repeat while waiting merges away
			if (hit && !q.full && !(q.chdef[i].filt && dup)) begin
				n.pend[i] = 1'b1;
			end
		end

		// Register writes
		if (bus_req.wr) begin
			if (bus_req.addr == OFS_CTRL) begin
				n.en = bus_req.wdata[CTRL_ENA_BIT];
				if (bus_req.wdata[CTRL_RST_BIT]) begin
					// Soft reset empties everything that holds log state
					n.wptr = 4'h0;
					n.rptr = 4'h0;
					n.full = 1'b0;
					n.pend = 16'h0;
					n.fifo = '0;
				end
			end else if (bus_req.addr == OFS_TSEL) begin
				n.tsel = bus_req.wdata[1:0]; // Logger held off by software
			end else if (bus_req.addr == OFS_WMARK) begin
				n.wmark = bus_req.wdata[3:0];
			end else if (bus_req.addr == OFS_PTR) begin
				// Writing the same index leaves full standing
				if (bus_req.wdata[3:0] != q.rptr) begin
					n.full = 1'b0;
				end
				n.rptr = bus_req.wdata[3:0];
			end else if (bus_req.addr == OFS_CHEN) begin
				n.chen = bus_req.wdata[15:0];
			end else if (bus_req.addr >= OFS_CHDEF && bus_req.addr <= OFS_CHDEF_E
					&& !bus_req.addr[0]) begin
				n.chdef[cidx].db   = bus_req.wdata[DEF_DB_BIT];
				n.chdef[cidx].pol  = bus_req.wdata[DEF_POL_BIT];
				n.chdef[cidx].filt = bus_req.wdata[DEF_FILT_BIT];
				n.chdef[cidx].sel  = bus_req.wdata[9:0];
			end
		end

		// Register reads, data in the following cycle only
		if (bus_req.rd) begin
			if (bus_req.addr == OFS_CTRL) begin
				n.rdata[CTRL_ENA_BIT] = q.en;
			end else if (bus_req.addr == OFS_TSEL) begin
				n.rdata[1:0] = q.tsel;
			end else if (bus_req.addr == OFS_WMARK) begin
				n.rdata[3:0] = q.wmark;
			end else if (bus_req.addr == OFS_PTR) begin
				n.rdata[PTR_FULL_BIT]           = q.flags.full;
				n.rdata[PTR_WM_BIT]             = q.flags.watermark;
				n.rdata[PTR_NE_BIT]             = q.flags.has_data;
				n.rdata[PTR_W_LSB+3:PTR_W_LSB] = q.wptr;
				n.rdata[3:0]                    = q.rptr;
			end else if (bus_req.addr == OFS_CHEN) begin
				n.rdata[15:0] = q.chen;
			end else if (bus_req.addr == OFS_CHSTS) begin
				n.rdata[15:0] = q.chsts;
			end else if (bus_req.addr >= OFS_CHDEF && bus_req.addr <= OFS_CHDEF_E
					&& !bus_req.addr[0]) begin
				n.rdata[DEF_DB_BIT]   = q.chdef[cidx].db;
				n.rdata[DEF_POL_BIT]  = q.chdef[cidx].pol;
				n.rdata[DEF_FILT_BIT] = q.chdef[cidx].filt;
				n.rdata[9:0]          = q.chdef[cidx].sel;
			end else if (bus_req.addr >= OFS_FIFO && bus_req.addr <= OFS_FIFO_E
					&& !bus_req.addr[0]) begin
				// Any entry, any order: even word id/pol, odd word stamp
				if (fofs[1]) begin
					n.rdata = q.fifo[fidx].stamp;
				end else begin
					n.rdata[ENT_POL_BIT] = q.fifo[fidx].pol;
					n.rdata[9:0]         = q.fifo[fidx].id;
				end
			end
		end

		// Flags follow the next indexes so they register with them
		free_n            = n.full ? 5'h0 : DEPTH - {1'b0, n.wptr - n.rptr};
		n.flags.full      = n.full;
		n.flags.has_data  = n.full || n.wptr != n.rptr;
		n.flags.watermark = free_n <= {1'b0, n.wmark};
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Whole state in one register, constant reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q       <= '0;
			q.wmark <= WMARK_RST;
		end else begin
			q <= n;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Free entries seen from registered indexes
	assign free_q = q.full ? 5'h0 : DEPTH - {1'b0, q.wptr - q.rptr};

	full_hold_a: assert property (
		q.full && !srst |=> $stable(q.wptr))
		else $error("write index moved while full");

	disabled_stop_a: assert property (
		!q.en && !srst |=> $stable(q.wptr))
		else $error("logged while logger disabled");

	step_gate_a: assert property (
		!step && !srst |=> $stable(q.wptr))
		else $error("logged without a logger step");

	one_step_a: assert property (
		!srst |=> q.wptr == $past(q.wptr) || q.wptr == $past(q.wptr) + 4'h1)
		else $error("more than one entry logged in a step");

	stamp_store_a: assert property (
		step && q.en && !q.full && |q.pend && !srst
		|=> q.fifo[$past(q.wptr)].stamp == $past(stamp_timer_value)
			&& q.wptr == $past(q.wptr) + 4'h1)
		else $error("entry stamp or index wrong");

	lowest_wins_a: assert property (
		step && q.en && !q.full && q.pend[0] && !srst
		|=> q.fifo[$past(q.wptr)].id == $past(q.chdef[0].sel) && !q.pend[0])
		else $error("lowest channel did not win");

	soft_reset_a: assert property (
		srst |=> q.wptr == 4'h0 && q.rptr == 4'h0 && !q.flags.full
			&& !q.flags.has_data && q.pend == 16'h0)
		else $error("soft reset left state behind");

	has_data_a: assert property (
		q.flags.has_data == (q.full || q.wptr != q.rptr))
		else $error("not-empty flag disagrees with indexes");

	watermark_a: assert property (
		q.flags.watermark == (free_q <= {1'b0, q.wmark}))
		else $error("watermark flag wrong");

	full_release_a: assert property (
		q.full && rptr_wr && bus_req.wdata[3:0] != q.rptr && !srst |=> !q.full)
		else $error("full not released by changed read index");

	full_keep_a: assert property (
		q.full && rptr_wr && bus_req.wdata[3:0] == q.rptr && !srst |=> q.full)
		else $error("full released by same read index");

	// Register port: answer stands one cycle, index writes land
	rdata_pulse_a: assert property (
		!bus_req.rd |=> bus_rdata == 32'h0)
		else $error("read data stood beyond one cycle");

	rptr_write_a: assert property (
		rptr_wr && !srst |=> q.rptr == $past(bus_req.wdata[3:0]))
		else $error("read index write did not land");

	// Full buffer: entries frozen and no new events queued
	no_overwrite_a: assert property (
		q.full && !srst |=> $stable(q.fifo))
		else $error("entry changed while buffer full");

	full_silent_a: assert property (
		q.full && !srst |=> (q.pend & ~$past(q.pend)) == 16'h0)
		else $error("event queued while buffer full");

	// Debounce: the qualified level moves only on the last count
	debounce_hold_a: assert property (
		q.chdef[0].db && q.dbc[0] != DB_LAST |=> $stable(q.qual[0]))
		else $error("debounced level changed too early");

	// Main scenarios reached
	log_cov: cover property (step && q.en && !q.full && |q.pend);
	full_cov: cover property ($rose(q.full));
	wmark_cov: cover property ($rose(q.flags.watermark));
	reset_cov: cover property (srst && q.flags.has_data);
	// Logging paced by the timer tick with the processor clock off
	tick_cov: cover property (!processor_clock_enable && timer_tick && q.en && |q.pend);

endmodule

// ===== elg_src_model.sv
/*
 * Model of the monitored sources: sixteen levels set by the bench,
 * a free-running time-stamp timer and a slow pacing tick.
 * Assumes the bench strobes new levels for sources 0 to 15.
 */
module elg_src_model
	import elg_pkg::*;
(
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst,
	// Level update from the bench
	input  wire logic            set_stb,
	input  wire logic [15:0]     set_lo,
	// Toward the logger
	output logic [NSRC-1:0]      source_levels,
	output logic [31:0]          stamp_timer_value,
	output logic                 timer_tick
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] div; // Tick divider

	// ---------------------------------------------------------------
	// Levels, timer count and tick pacing
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			source_levels     <= '0;
			stamp_timer_value <= '0;
			div               <= '0;
		end else begin
			stamp_timer_value <= stamp_timer_value + 32'h1;
			div               <= div + 2'h1;
			// New levels land together, so edges can coincide
			if (set_stb) begin
				source_levels[15:0] <= set_lo;
			end
		end
	end

	// One-cycle pulse every fourth cycle
	// Divider and count start together, so a tick always meets a count ending in 2'b11
	assign timer_tick = (div == 2'h3);
endmodule

// ===== test_edge_event_logger.sv
/*
 * Self-checking bench for the edge event logger: register table,
 * edge capture, priority, filter, enables, soft reset and full handling.
 * Assumes the source model in its own file and the processor clock on until the last test turns it off.
 */
module test_edge_event_logger
	import elg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [19:0] a; // Offset
		logic [31:0] d; // Write data
		logic        w; // Write first
		logic [31:0] e; // Expected read
	} elg_row_t;

	// Ordinary register cases
	localparam elg_row_t ROWS [15] = '{
		'{OFS_CTRL, 32'h0, 1'b0, 32'h0},
		'{OFS_TSEL, 32'h0, 1'b0, 32'h0},
		'{OFS_WMARK, 32'h0, 1'b0, 32'h1},
		'{OFS_PTR, 32'h0, 1'b0, 32'h0},
		'{OFS_CHEN, 32'h0, 1'b0, 32'h0},
		'{OFS_CHDEF_E, 32'h0, 1'b0, 32'h0},
		'{OFS_FIFO, 32'h0, 1'b0, 32'h0},
		'{20'h48002, 32'hffffffff, 1'b1, 32'h0},
		'{OFS_TSEL, 32'hffffffff, 1'b1, 32'h3},
		'{OFS_TSEL, 32'h0, 1'b1, 32'h0},
		'{OFS_WMARK, 32'hffffffff, 1'b1, 32'hf},
		'{OFS_WMARK, 32'ha, 1'b1, 32'ha},
		'{OFS_CHDEF_E, 32'hffffffff, 1'b1, 32'he3ff},
		'{OFS_CHDEF_E, 32'h0, 1'b1, 32'h0},
		'{OFS_FIFO_E, 32'hffffffff, 1'b1, 32'h0}
	};
	// Entries expected after the first burst
	localparam logic [31:0] ENT [5] = '{32'h1006, 32'h5, 32'h4, 32'h3, 32'h1006};

	logic            sys_clk;   // Logger clock
	logic            rst;       // Reset
	elg_bus_req_t    bus_req;   // Register request
	logic [31:0]     bus_rdata; // Register answer
	logic            pce;       // Processor clock running
	logic            tick;      // Timer tick
	logic [31:0]     stamp;     // Timer count
	logic [1:0]      tsel;      // Timer select copy
	logic [NSRC-1:0] src;       // Source levels
	elg_flags_t      flags;     // Status flags
	logic            set_stb;   // Level update strobe
	logic [15:0]     set_lo;    // New levels
	logic [31:0]     last_t;    // Timer when levels changed
	logic [31:0]     rd_val;    // Last read data
	int              errors;
	int              n_checks;

	// ---------------------------------------------------------------
	// Design, source model and clock
	// ---------------------------------------------------------------
	elg_logger uut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.processor_clock_enable(pce), .timer_tick(tick), .stamp_timer_value(stamp),
		.stamp_timer_select(tsel), .source_levels(src), .log_flags(flags));
	elg_src_model u_src (.sys_clk(sys_clk), .rst(rst), .set_stb(set_stb), .set_lo(set_lo),
		.source_levels(src), .stamp_timer_value(stamp), .timer_tick(tick));

	always #5 sys_clk = ~sys_clk;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [19:0] a);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		rd_val = bus_rdata;
	endtask

	// New source levels, then time to log
	task automatic lv(input logic [15:0] v);
		@(posedge sys_clk);
		set_stb <= 1'b1;
		set_lo  <= v;
		@(posedge sys_clk);
		set_stb <= 1'b0;
		#1;
		last_t = stamp;
		repeat (5) @(posedge sys_clk);
	endtask

	task automatic chk_ptr(input logic [31:0] e);
		rd(OFS_PTR);
		chk("pointer", rd_val, e);
	endtask

	task automatic give_verdict;
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		sys_clk  = 1'b0;
		rst      = 1'b1;
		bus_req  = '0;
		pce      = 1'b1;
		set_stb  = 1'b0;
		set_lo   = 16'h0;
		last_t   = 32'h0;
		rd_val   = 32'h0;
		errors   = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk("flags", {29'h0, flags}, 32'h0);
		foreach (ROWS[i]) begin
			if (ROWS[i].w) begin
				wr(ROWS[i].a, ROWS[i].d);
			end
			rd(ROWS[i].a);
			chk("register", rd_val, ROWS[i].e);
		end
		// Channels: rising on 5, 4, 3 and falling on 6
		wr(OFS_CHDEF, 32'h5);
		wr(OFS_CHDEF + 20'h2, 32'h4);
		wr(OFS_CHDEF + 20'h4, 32'h3);
		wr(OFS_CHDEF + 20'h6, 32'h4006);
		wr(OFS_CHEN, 32'hf);
		wr(OFS_CTRL, 32'h1);
		repeat (4) @(posedge sys_clk);
		lv(16'h0020);
		rd(OFS_FIFO + 20'h6);
		chk("stamp", rd_val, last_t + 32'h1);
		lv(16'h0038);
		lv(16'h0078);
		lv(16'h0038);
		for (int i = 0; i < 5; i++) begin
			rd(OFS_FIFO + 20'(4 * i));
			chk("entry", rd_val, ENT[i]);
		end
		chk_ptr(32'h10500);
		// Watermark at eleven free entries
		wr(OFS_WMARK, 32'hb);
		repeat (3) @(posedge sys_clk);
		chk("watermark", {31'h0, flags.watermark}, 32'h1);
		wr(OFS_WMARK, 32'ha);
		repeat (3) @(posedge sys_clk);
		chk("watermark", {31'h0, flags.watermark}, 32'h0);
		// Repeat filter on source 5
		wr(OFS_CHEN, 32'he);
		wr(OFS_CHDEF, 32'h2005);
		wr(OFS_CHEN, 32'hf);
		lv(16'h0018);
		lv(16'h0038);
		chk_ptr(32'h10500);
		wr(OFS_PTR, 32'h2);
		lv(16'h0018);
		lv(16'h0038);
		chk_ptr(32'h10602);
		// Channel off while logging
		wr(OFS_CHEN, 32'he);
		lv(16'h0018);
		lv(16'h0038);
		chk_ptr(32'h10602);
		// Logger off; timer select changed only while off
		wr(OFS_CTRL, 32'h0);
		wr(OFS_TSEL, 32'h2);
		repeat (2) @(posedge sys_clk);
		chk("timer select", {30'h0, tsel}, 32'h2);
		lv(16'h0028);
		lv(16'h0038);
		chk_ptr(32'h10602);
		// Soft reset
		wr(OFS_CTRL, 32'h2);
		repeat (2) @(posedge sys_clk);
		chk_ptr(32'h0);
		rd(OFS_FIFO);
		chk("entry", rd_val, 32'h0);
		// Initial levels log three, then fill to sixteen
		wr(OFS_CTRL, 32'h1);
		repeat (5) @(posedge sys_clk);
		for (int i = 0; i < 13; i++) begin
			lv(16'h0030);
			lv(16'h0038);
		end
		chk_ptr(32'h70000);
		chk("flags", {29'h0, flags}, 32'h7);
		lv(16'h0030);
		lv(16'h0038);
		chk_ptr(32'h70000);
		rd(OFS_FIFO);
		chk("entry", rd_val, 32'h4);
		// Same read index keeps full, a new one releases it
		wr(OFS_PTR, 32'h0);
		lv(16'h0030);
		lv(16'h0038);
		chk_ptr(32'h70000);
		wr(OFS_PTR, 32'h1);
		lv(16'h0030);
		lv(16'h0038);
		chk_ptr(32'h70101);
		rd(OFS_FIFO);
		chk("entry", rd_val, 32'h3);
		// Release full, then a one-cycle glitch on a debounced channel
		wr(OFS_PTR, 32'h5);
		wr(OFS_CHDEF, 32'h8005);
		wr(OFS_CHEN, 32'hf);
		lv(16'h0018);
		@(posedge sys_clk);
		set_stb <= 1'b1;
		set_lo  <= 16'h0038;
		@(posedge sys_clk);
		set_lo  <= 16'h0018;
		@(posedge sys_clk);
		set_stb <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk_ptr(32'h30105);
		lv(16'h0038);
		repeat (2) @(posedge sys_clk);
		chk_ptr(32'h30205);
		// Processor clock off: the timer tick paces capture
		@(posedge sys_clk);
		pce <= 1'b0;
		lv(16'h0030);
		lv(16'h0038);
		repeat (4) @(posedge sys_clk);
		chk_ptr(32'h30305);
		rd(OFS_FIFO + 20'ha);
		chk("tick stamp", {30'h0, rd_val[1:0]}, 32'h3);
		give_verdict();
	end

	// Watchdog well beyond the expected run
	initial begin
		#100000;
		errors++;
		give_verdict();
	end
endmodule
